//--- verilog/tdf_map.vh
// Constants for the transmit descriptor fetch engine: block layout, fields, opcodes.
// Assumes the includer uses the names only; no logic here.
`ifndef TDF_MAP_VH
`define TDF_MAP_VH
`define TDF_BIT_EOL 31
`define TDF_BIT_SUSP 30
`define TDF_BIT_IDONE 29
`define TDF_CID_HI 28
`define TDF_CID_LO 24
`define TDF_BIT_NOINS 20
`define TDF_BIT_MODE 19
`define TDF_CMD_HI 18
`define TDF_CMD_LO 16
`define TDF_OP_XMIT 3'h4
`define TDF_BIT_DONE 15
`define TDF_BIT_OK 13
`define TDF_BIT_UNDR 12
`define TDF_OFS_ARRAY 32'h00000008
`define TDF_OFS_COUNT 32'h0000000c
`define TDF_OFS_DATA 32'h00000010
`define TDF_OFS_EMB 32'h00000010
`define TDF_OFS_EXT_DATA 32'h00000020
`define TDF_NULL_PTR 32'hffffffff
`define TDF_BD_SIZE 32'h00000008
`define TDF_BD_EOL 15
`define TDF_MAX_INBLK 14'h0a28
`define TDF_THR_UNIT 3
`define TDF_CID_UNIT 16
`endif

//--- verilog/tdf_engine.v
// Transmit command engine: fetches a transmit command block, walks its descriptors,
// streams frame bytes to the transmit FIFO and writes completion status back.
// Assumes a word-wide memory master that answers a read in mem_rvalid and accepts
// writes in one cycle; the FIFO level and underrun pulse come from the wire side.
// One read is outstanding at a time; a descriptor is fetched only when its buffer
// is due, so descriptor reads never overlap the byte stream.
//
// Behaviour
// - End-of-list set: go idle after block, always raise idle interrupt.
// - Suspend set, end-of-list clear: go suspended after block; idle interrupt only if enabled.
// - Done interrupt raised after block only when its flag is set.
// - Five-bit field delays the idle interrupt.
// - No-insert clear: insert CRC and address, or CRC only if option set.
// - Mode 0 simplified data follows block; mode 1 adds descriptor data.
// - Transmit command recognised by opcode 100b in bits 18:16.
// - Completion flag set when last data byte has been moved.
// - No status written after the frame leaves the wire.
// - No-error flag always set together with completion.
// - Underrun flag reports underruns since last status write-back.
// - Array pointer addresses two-word descriptors; null in simplified mode.
// - Zero descriptor count means null pointer and whole frame in block.
// - Transmission starts once FIFO holds threshold times 8 bytes.
// - In-block bytes read from block address plus 10h (plus 20h for an extended block), up to 2600.
// - Simplified count is whole frame; flexible zero count uses buffers only.
// - Extended block is eight words with two embedded descriptors.
// - Extended block is treated as flexible mode.
// - Buffer pointers are absolute, no base added.
// - Descriptor size gives buffer bytes; its end flag ends the frame.
// - Dynamic mode: zero buffer pointer discarded and descriptor refetched. Code does this for array descriptors only; embedded pointers are used as is.
`default_nettype none
`include "tdf_map.vh"
module tdf_engine #(
    parameter CNT_W = 14
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Command unit control
    input wire start,
    input wire [31:0] cu_base,
    input wire [31:0] block_ptr,
    input wire ext_block_en,
    input wire dyn_desc_en,
    input wire no_source_addr_option,
    input wire idle_int_on_suspend,
    // Memory master
    output reg mem_rd,
    output reg mem_wr,
    output reg [31:0] mem_addr,
    output reg [31:0] mem_wdata,
    input wire mem_rvalid,
    input wire [31:0] mem_rdata,
    // Transmit FIFO and wire side
    output reg fifo_wr,
    output reg [7:0] fifo_data,
    output reg fifo_last,
    input wire fifo_ready,
    input wire [11:0] fifo_level,
    input wire underrun_pulse,
    output reg tx_start,
    output reg insert_crc,
    output reg insert_src_addr,
    // Command unit state and events
    output reg busy,
    output reg cu_suspended,
    output reg cu_idle,
    output reg command_done_interrupt,
    output reg command_unit_idle_interrupt,
    output reg bad_command
);
    localparam S_IDLE = 4'h0;
    localparam S_HDR = 4'h1;
    localparam S_WAIT = 4'h2;
    localparam S_INB = 4'h3;
    localparam S_BDA = 4'h4;
    localparam S_BDB = 4'h5;
    localparam S_BUF = 4'h6;
    localparam S_STAT = 4'h7;
    localparam S_FIN = 4'h8;
    localparam S_DLY = 4'h9;

    reg [3:0] st_ff;
    reg [2:0] word_ff;
    // Copies of the block header and of the two embedded descriptors
    reg [31:0] cmd_ff;
    reg [31:0] arr_ff;
    reg [31:0] cnt_ff;
    reg [31:0] emb_ptr0_ff;
    reg [31:0] emb_ptr1_ff;
    reg [31:0] emb_sz0_ff;
    reg [31:0] emb_sz1_ff;
    // Data and descriptor walk
    reg [31:0] rd_addr_ff;
    reg [CNT_W-1:0] bytes_ff;
    reg [7:0] bd_left_ff;
    reg [7:0] bd_idx_ff;
    reg [31:0] bd_ptr_ff;
    reg bd_last_ff;
    reg [31:0] word_data_ff;
    reg [1:0] lane_ff;
    reg have_word_ff;
    reg rd_pend_ff;
    // Status and interrupt timing
    reg underrun_ff;
    reg [8:0] dly_ff;
    reg from_bd_ff;

    wire [31:0] blk_addr = cu_base + block_ptr;
    wire flexible = cmd_ff[`TDF_BIT_MODE] | ext_block_en;
    wire [7:0] bd_count = cnt_ff[31:24];
    wire [7:0] thresh = cnt_ff[23:16];
    wire [CNT_W-1:0] inblk_cnt = cnt_ff[CNT_W-1:0];
    wire no_array = (bd_count == 8'h00) | (arr_ff == `TDF_NULL_PTR) | ~flexible;
    // Threshold in bytes; a zero field never starts a frame
    wire [11:0] thr_bytes = {1'b0, thresh, `TDF_THR_UNIT'h0};
    wire [CNT_W-1:0] inblk_lim = (inblk_cnt > `TDF_MAX_INBLK) ? `TDF_MAX_INBLK : inblk_cnt;
    wire [7:0] emb_n = ext_block_en ? 8'h02 : 8'h00;
    // Embedded descriptors of an extended block need no memory read
    wire use_emb = bd_idx_ff < emb_n;
    // Idle interrupt delay: sixteen clocks per step of the field
    wire [8:0] cid_clocks = {cmd_ff[`TDF_CID_HI:`TDF_CID_LO], 4'h0};

    // Status half: completion and no-error always together, underrun since last write-back
    reg [15:0] stat_lo;
    always @* begin
        stat_lo = 16'h0000;
        stat_lo[`TDF_BIT_DONE] = 1'b1;
        stat_lo[`TDF_BIT_OK] = 1'b1;
        stat_lo[`TDF_BIT_UNDR] = underrun_ff | underrun_pulse;
    end

    // Header word offset in block layout
    function [31:0] hdr_ofs;
        input [2:0] w;
        begin
            hdr_ofs = {27'h0, w, 2'h0};
        end
    endfunction

    // Frame ends when no descriptor is left or the current one carried its end flag
    function frame_end;
        input [7:0] left;
        input from_bd;
        input last;
        begin
            frame_end = (left == 8'h00) | (from_bd & last);
        end
    endfunction

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= S_IDLE;
            word_ff <= 3'h0;
            cmd_ff <= 32'h0;
            arr_ff <= 32'h0;
            cnt_ff <= 32'h0;
            emb_ptr0_ff <= 32'h0;
            emb_ptr1_ff <= 32'h0;
            emb_sz0_ff <= 32'h0;
            emb_sz1_ff <= 32'h0;
            rd_addr_ff <= 32'h0;
            bytes_ff <= {CNT_W{1'b0}};
            bd_left_ff <= 8'h0;
            bd_idx_ff <= 8'h0;
            bd_ptr_ff <= 32'h0;
            bd_last_ff <= 1'b0;
            word_data_ff <= 32'h0;
            lane_ff <= 2'h0;
            have_word_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            underrun_ff <= 1'b0;
            dly_ff <= 9'h0;
            from_bd_ff <= 1'b0;
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            mem_addr <= 32'h0;
            mem_wdata <= 32'h0;
            fifo_wr <= 1'b0;
            fifo_data <= 8'h0;
            fifo_last <= 1'b0;
            tx_start <= 1'b0;
            insert_crc <= 1'b0;
            insert_src_addr <= 1'b0;
            busy <= 1'b0;
            cu_suspended <= 1'b0;
            cu_idle <= 1'b1;
            command_done_interrupt <= 1'b0;
            command_unit_idle_interrupt <= 1'b0;
            bad_command <= 1'b0;
        end else begin
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            fifo_wr <= 1'b0;
            fifo_last <= 1'b0;
            command_done_interrupt <= 1'b0;
            command_unit_idle_interrupt <= 1'b0;
            bad_command <= 1'b0;
            // Underruns gather until the next status write; a new one wins over the clear
            if (underrun_pulse) begin
                underrun_ff <= 1'b1;
            end
            if (busy && fifo_level >= thr_bytes && thresh != 8'h00) begin
                tx_start <= 1'b1;
            end
            case (st_ff)
                S_IDLE: begin
                    if (start) begin
                        busy <= 1'b1;
                        cu_idle <= 1'b0;
                        cu_suspended <= 1'b0;
                        tx_start <= 1'b0;
                        word_ff <= 3'h0;
                        rd_pend_ff <= 1'b0;
                        st_ff <= S_HDR;
                    end
                end

                // One read outstanding; the link word is read and dropped
                S_HDR: begin
                    if (!rd_pend_ff) begin
                        mem_rd <= 1'b1;
                        mem_addr <= blk_addr + hdr_ofs(word_ff);
                        rd_pend_ff <= 1'b1;
                    end else if (mem_rvalid) begin
                        rd_pend_ff <= 1'b0;
                        case (word_ff)
                            3'h0: cmd_ff <= mem_rdata;
                            3'h2: arr_ff <= mem_rdata;
                            3'h3: cnt_ff <= mem_rdata;
                            3'h4: emb_ptr0_ff <= mem_rdata;
                            3'h5: emb_sz0_ff <= mem_rdata;
                            3'h6: emb_ptr1_ff <= mem_rdata;
                            3'h7: emb_sz1_ff <= mem_rdata;
                            default: ;
                        endcase
                        if (word_ff == (ext_block_en ? 3'h7 : 3'h3)) begin
                            st_ff <= S_WAIT;
                        end else begin
                            word_ff <= word_ff + 3'h1;
                        end
                    end
                end

                // A refused opcode ends the block with no status write
                S_WAIT: begin
                    if (cmd_ff[`TDF_CMD_HI:`TDF_CMD_LO] != `TDF_OP_XMIT) begin
                        bad_command <= 1'b1;
                        st_ff <= S_FIN;
                    end else begin
                        insert_crc <= ~cmd_ff[`TDF_BIT_NOINS];
                        insert_src_addr <= ~cmd_ff[`TDF_BIT_NOINS] & ~no_source_addr_option;
                        bd_idx_ff <= 8'h0;
                        bd_left_ff <= no_array ? 8'h00 : bd_count;
                        have_word_ff <= 1'b0;
                        from_bd_ff <= 1'b0;
                        bytes_ff <= inblk_lim;
                        rd_addr_ff <= blk_addr + (ext_block_en ? `TDF_OFS_EXT_DATA : `TDF_OFS_DATA);
                        st_ff <= (inblk_lim != {CNT_W{1'b0}}) ? S_INB : S_BDA;
                    end
                end

                // Bytes leave little-endian, from the lane the address points at
                S_INB, S_BUF: begin
                    if (bytes_ff == {CNT_W{1'b0}}) begin
                        st_ff <= S_BDA;
                    end else if (!have_word_ff) begin
                        if (!rd_pend_ff) begin
                            mem_rd <= 1'b1;
                            mem_addr <= {rd_addr_ff[31:2], 2'h0};
                            lane_ff <= rd_addr_ff[1:0];
                            rd_pend_ff <= 1'b1;
                        end else if (mem_rvalid) begin
                            rd_pend_ff <= 1'b0;
                            word_data_ff <= mem_rdata;
                            have_word_ff <= 1'b1;
                        end
                    end else if (fifo_ready) begin
                        fifo_wr <= 1'b1;
                        fifo_data <= word_data_ff[{lane_ff, 3'h0} +: 8];
                        bytes_ff <= bytes_ff - {{(CNT_W-1){1'b0}}, 1'b1};
                        rd_addr_ff <= rd_addr_ff + 32'h1;
                        lane_ff <= lane_ff + 2'h1;
                        if (lane_ff == 2'h3) begin
                            have_word_ff <= 1'b0;
                        end
                        if (bytes_ff == {{(CNT_W-1){1'b0}}, 1'b1}) begin
                            have_word_ff <= 1'b0;
                            if (frame_end(bd_left_ff, from_bd_ff, bd_last_ff)) begin
                                fifo_last <= 1'b1;
                                st_ff <= S_STAT;
                            end
                        end
                    end
                end

                // Dynamic mode drops a zero pointer read from the array and reads the same descriptor again; embedded ones are used as is
                S_BDA: begin
                    if (frame_end(bd_left_ff, from_bd_ff, bd_last_ff)) begin
                        fifo_last <= 1'b1;
                        st_ff <= S_STAT;
                    end else if (use_emb) begin
                        bd_ptr_ff <= bd_idx_ff[0] ? emb_ptr1_ff : emb_ptr0_ff;
                        word_data_ff <= bd_idx_ff[0] ? emb_sz1_ff : emb_sz0_ff;
                        st_ff <= S_BDB;
                    end else if (!rd_pend_ff) begin
                        mem_rd <= 1'b1;
                        mem_addr <= arr_ff + {21'h0, bd_idx_ff - emb_n, 3'h0};
                        rd_pend_ff <= 1'b1;
                    end else if (mem_rvalid) begin
                        rd_pend_ff <= 1'b0;
                        if (dyn_desc_en && mem_rdata == 32'h0) begin
                            st_ff <= S_BDA;
                        end else begin
                            bd_ptr_ff <= mem_rdata;
                            mem_rd <= 1'b1;
                            mem_addr <= arr_ff + {21'h0, bd_idx_ff - emb_n, 3'h4};
                            rd_pend_ff <= 1'b1;
                            st_ff <= S_BDB;
                        end
                    end
                end

                S_BDB: begin
                    if (use_emb || mem_rvalid) begin
                        rd_pend_ff <= 1'b0;
                        from_bd_ff <= 1'b1;
                        bd_idx_ff <= bd_idx_ff + 8'h1;
                        bd_left_ff <= bd_left_ff - 8'h1;
                        bd_last_ff <= use_emb ? word_data_ff[`TDF_BD_EOL]
                                              : mem_rdata[`TDF_BD_EOL];
                        bytes_ff <= use_emb ? word_data_ff[CNT_W-1:0]
                                            : mem_rdata[CNT_W-1:0];
                        rd_addr_ff <= bd_ptr_ff;
                        have_word_ff <= 1'b0;
                        st_ff <= S_BUF;
                    end
                end

                // Only status write of the block; nothing follows once the frame is out
                S_STAT: begin
                    mem_wr <= 1'b1;
                    mem_addr <= blk_addr;
                    mem_wdata <= {cmd_ff[31:16], stat_lo};
                    underrun_ff <= 1'b0;
                    if (underrun_pulse) begin
                        underrun_ff <= 1'b1;
                    end
                    st_ff <= S_FIN;
                end

                // Done pulse follows the status write by one clock
                S_FIN: begin
                    command_done_interrupt <= cmd_ff[`TDF_BIT_IDONE] & ~bad_command;
                    busy <= 1'b0;
                    dly_ff <= cid_clocks;
                    if (cmd_ff[`TDF_BIT_EOL]) begin
                        cu_idle <= 1'b1;
                        st_ff <= S_DLY;
                    end else if (cmd_ff[`TDF_BIT_SUSP]) begin
                        cu_suspended <= 1'b1;
                        st_ff <= idle_int_on_suspend ? S_DLY : S_IDLE;
                    end else begin
                        st_ff <= S_IDLE;
                    end
                end

                // Idle interrupt held back by the programmed delay
                S_DLY: begin
                    if (dly_ff == 9'h0) begin
                        command_unit_idle_interrupt <= 1'b1;
                        st_ff <= S_IDLE;
                    end else begin
                        dly_ff <= dly_ff - 9'h1;
                    end
                end
                default: st_ff <= S_IDLE;
            endcase
        end
    end
endmodule // tdf_engine
`default_nettype wire

//--- tb/tdf_engine_checker.sv
// Port checker for the transmit command engine, bound to every engine instance.
// Assumes one clock domain and an active-low asynchronous reset.
`default_nettype none
module tdf_engine_checker #(
    parameter CNT_W = 14
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Configuration
    input wire logic no_source_addr_option,
    input wire logic idle_int_on_suspend,
    // Status write-back
    input wire logic mem_wr,
    input wire logic [31:0] mem_wdata,
    // Wire side
    input wire logic tx_start,
    input wire logic insert_crc,
    input wire logic insert_src_addr,
    // State and events
    input wire logic busy,
    input wire logic cu_suspended,
    input wire logic cu_idle,
    input wire logic command_done_interrupt,
    input wire logic command_unit_idle_interrupt,
    input wire logic bad_command
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_done_wr: assert property (command_done_interrupt |-> $past(mem_wr) && $past(mem_wdata[29]))
        else $error("done pulse without a flagged status write");
    a_no_done: assert property (mem_wr && !mem_wdata[29] |=> !command_done_interrupt)
        else $error("done pulse with flag clear");
    a_stat_flags: assert property (mem_wr |-> mem_wdata[15] && mem_wdata[13] && mem_wdata[11:0] == 12'h0)
        else $error("status write lacks completion or ok");
    a_stat_op: assert property (mem_wr |-> mem_wdata[18:16] == 3'h4)
        else $error("status written for a non-transmit opcode");
    a_bad_no_wr: assert property (bad_command |=> !mem_wr [*8])
        else $error("status written after a refused command");
    a_idle_el: assert property (mem_wr && mem_wdata[31] |-> ##[1:4] cu_idle)
        else $error("no idle state after end of list");
    a_idle_int: assert property (mem_wr && mem_wdata[31] |-> ##[1:520] command_unit_idle_interrupt)
        else $error("no idle interrupt after end of list");
    a_susp_enter: assert property (mem_wr && mem_wdata[30] && !mem_wdata[31] |-> ##[1:4] cu_suspended)
        else $error("no suspend after suspend flag");
    a_susp_quiet: assert property (mem_wr && mem_wdata[30] && !mem_wdata[31] && !idle_int_on_suspend
        |=> !command_unit_idle_interrupt [*8])
        else $error("idle interrupt on suspend while disabled");
    a_src_crc: assert property (insert_src_addr |-> insert_crc && !no_source_addr_option)
        else $error("source address inserted against option");
    a_tx_busy: assert property ($rose(tx_start) |-> busy)
        else $error("transmission started while not busy");
endmodule // tdf_engine_checker

bind tdf_engine tdf_engine_checker #(.CNT_W(CNT_W)) tdf_engine_checker_inst (
    .clk(clk), .rst_n(rst_n), .no_source_addr_option(no_source_addr_option),
    .idle_int_on_suspend(idle_int_on_suspend), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .tx_start(tx_start), .insert_crc(insert_crc), .insert_src_addr(insert_src_addr),
    .busy(busy), .cu_suspended(cu_suspended), .cu_idle(cu_idle),
    .command_done_interrupt(command_done_interrupt),
    .command_unit_idle_interrupt(command_unit_idle_interrupt), .bad_command(bad_command)
);
`default_nettype wire

//--- tb/tdf_mem_model.sv
// Host memory model: 256 words, one outstanding read, answer after lat cycles.
// Assumes the bench loads the words by hierarchical reference before a start.
`default_nettype none
module tdf_mem_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Answer latency, at least 1
    input wire logic [3:0] lat,
    // Memory bus
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic mem_rvalid,
    output logic [31:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [0:255];
    logic [3:0] wait_ff;
    logic [7:0] idx_ff;
    logic pend_ff;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_ff <= 1'b0;
            wait_ff <= 4'h0;
            idx_ff <= 8'h0;
            mem_rvalid <= 1'b0;
            mem_rdata <= 32'h0;
        end else begin
            mem_rvalid <= 1'b0;
            // Data lines invert every clock outside an answer, so no word holds steady
            mem_rdata <= ~mem_rdata;
            if (mem_wr) begin
                mem[mem_addr[9:2]] <= mem_wdata;
            end
            if (mem_rd) begin
                pend_ff <= 1'b1;
                wait_ff <= lat;
                idx_ff <= mem_addr[9:2];
            end else if (pend_ff && wait_ff > 4'h1) begin
                wait_ff <= wait_ff - 4'h1;
            end else if (pend_ff) begin
                pend_ff <= 1'b0;
                mem_rvalid <= 1'b1;
                mem_rdata <= mem[idx_ff];
            end
        end
    end
endmodule // tdf_mem_model
`default_nettype wire

//--- tb/tb_transmit_descriptor_fetch.sv
// Testbench: simplified, extended and refused command blocks against the memory model.
// Assumes the engine, its checker and the memory model are compiled first.
`default_nettype none
module tb_transmit_descriptor_fetch;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic start = 1'b0;
    logic [31:0] cu_base = 32'h100;
    logic [31:0] block_ptr = 32'h0;
    logic ext_block_en = 1'b0;
    logic dyn_desc_en = 1'b0;
    logic no_source_addr_option = 1'b0;
    logic idle_int_on_suspend = 1'b0;
    logic fifo_ready = 1'b1;
    logic [11:0] fifo_level = 12'h0;
    logic underrun_pulse = 1'b0;
    logic [3:0] lat = 4'h1;
    logic stall = 1'b0;
    logic mem_rd, mem_wr, mem_rvalid, fifo_wr, fifo_last, tx_start, insert_crc;
    logic insert_src_addr, busy, cu_suspended, cu_idle, cmd_done, idle_int, bad_command;
    logic [31:0] mem_addr, mem_wdata, mem_rdata, wr_addr, wr_data;
    logic [7:0] fifo_data;
    logic [7:0] got[$];
    int bad_count = 0;
    int n_compared = 0;
    int n_wr, n_done, n_idle, n_bad, n_last, n_ptr_rd, wr_cyc, idle_cyc;
    int cyc = 0;

    tdf_engine tdf_engine_inst (
        .clk(clk), .rst_n(rst_n), .start(start), .cu_base(cu_base), .block_ptr(block_ptr),
        .ext_block_en(ext_block_en), .dyn_desc_en(dyn_desc_en),
        .no_source_addr_option(no_source_addr_option),
        .idle_int_on_suspend(idle_int_on_suspend), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rvalid(mem_rvalid),
        .mem_rdata(mem_rdata), .fifo_wr(fifo_wr), .fifo_data(fifo_data),
        .fifo_last(fifo_last), .fifo_ready(fifo_ready), .fifo_level(fifo_level),
        .underrun_pulse(underrun_pulse), .tx_start(tx_start), .insert_crc(insert_crc),
        .insert_src_addr(insert_src_addr), .busy(busy), .cu_suspended(cu_suspended),
        .cu_idle(cu_idle), .command_done_interrupt(cmd_done),
        .command_unit_idle_interrupt(idle_int), .bad_command(bad_command)
    );
    tdf_mem_model tdf_mem_model_inst (
        .clk(clk), .rst_n(rst_n), .lat(lat), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rvalid(mem_rvalid),
        .mem_rdata(mem_rdata)
    );

    always #4 clk = ~clk;
    always @(posedge clk) fifo_ready <= stall ? ~fifo_ready : 1'b1;
    always @(posedge clk) begin
        cyc++;
        if (fifo_wr) got.push_back(fifo_data);
        if (fifo_last) n_last++;
        // Buffer pointer of the first array descriptor turns valid only at its second read, like a late driver
        if (mem_rd && mem_addr == 32'h1c0 && dyn_desc_en) begin
            n_ptr_rd++;
            if (n_ptr_rd == 2) tdf_mem_model_inst.mem[112] = 32'h00000208;
        end
        if (mem_wr) begin
            n_wr++;
            wr_addr = mem_addr;
            wr_data = mem_wdata;
            wr_cyc = cyc;
        end
        if (cmd_done) n_done++;
        if (idle_int) begin
            n_idle++;
            idle_cyc = cyc;
        end
        if (bad_command) n_bad++;
    end

    task automatic test_done();
        if (bad_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic chk_bytes(input logic [7:0] e[$]);
        chk(32'(got.size()), 32'(e.size()));
        foreach (e[i]) chk({24'h0, got[i]}, {24'h0, e[i]});
    endtask
    task automatic rst_dut();
        rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
    endtask
    task automatic go();
        int k;
        got.delete();
        {n_wr, n_done, n_idle, n_bad, n_last, n_ptr_rd} = '0;
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        for (k = 0; k < 3000 && n_wr == 0 && n_bad == 0; k++) @(posedge clk);
        if (k == 3000) begin
            bad_count++;
            $display("[FAIL] %0t engine never finished", $time);
            test_done();
        end
        repeat (40) @(posedge clk);
        #1;
    endtask

    task automatic sc_simple();
        rst_dut();
        tdf_mem_model_inst.mem[64] = 32'ha1040000;
        tdf_mem_model_inst.mem[66] = 32'hffffffff;
        tdf_mem_model_inst.mem[67] = 32'h00020005;
        tdf_mem_model_inst.mem[68] = 32'h44332211;
        tdf_mem_model_inst.mem[69] = 32'h00000055;
        fifo_level <= 12'd15;
        go();
        chk_bytes({8'h11, 8'h22, 8'h33, 8'h44, 8'h55});
        chk(wr_addr, 32'h100);
        chk(wr_data, 32'ha104a000);
        chk(32'(n_done), 32'h1);
        chk(32'(n_idle), 32'h1);
        chk(32'(n_last), 32'h1);
        chk(32'((idle_cyc - wr_cyc) inside {[16:18]}), 32'h1);
        chk({31'h0, cu_idle}, 32'h1);
        chk({31'h0, tx_start}, 32'h0);
        chk({30'h0, insert_crc, insert_src_addr}, 32'h3);
    endtask
    task automatic sc_ext();
        rst_dut();
        tdf_mem_model_inst.mem[80] = 32'h40040000;
        tdf_mem_model_inst.mem[82] = 32'h000001c0;
        tdf_mem_model_inst.mem[83] = 32'hff010000;
        tdf_mem_model_inst.mem[84] = 32'h00000200;
        tdf_mem_model_inst.mem[85] = 32'h00000002;
        tdf_mem_model_inst.mem[86] = 32'h00000204;
        tdf_mem_model_inst.mem[87] = 32'h00000001;
        tdf_mem_model_inst.mem[112] = 32'h00000000;
        tdf_mem_model_inst.mem[113] = 32'h00008001;
        tdf_mem_model_inst.mem[114] = 32'h0000020c;
        tdf_mem_model_inst.mem[115] = 32'h00000001;
        tdf_mem_model_inst.mem[128] = 32'h0000bbaa;
        tdf_mem_model_inst.mem[129] = 32'h000000cc;
        tdf_mem_model_inst.mem[130] = 32'h000000dd;
        tdf_mem_model_inst.mem[131] = 32'h000000ee;
        {block_ptr, ext_block_en, no_source_addr_option} <= {32'h40, 2'b11};
        {fifo_level, lat, stall, dyn_desc_en} <= {12'd8, 4'h3, 2'b11};
        @(posedge clk);
        underrun_pulse <= 1'b1;
        @(posedge clk);
        underrun_pulse <= 1'b0;
        go();
        chk_bytes({8'haa, 8'hbb, 8'hcc, 8'hdd});
        chk(wr_addr, 32'h140);
        chk(wr_data, 32'h4004b000);
        chk(32'(n_ptr_rd), 32'h2);
        chk(32'(n_last), 32'h1);
        chk(32'(n_done + n_idle), 32'h0);
        chk({31'h0, cu_suspended}, 32'h1);
        chk({31'h0, tx_start}, 32'h1);
        chk({30'h0, insert_crc, insert_src_addr}, 32'h2);
    endtask
    task automatic sc_bad();
        rst_dut();
        tdf_mem_model_inst.mem[96] = 32'h80030000;
        tdf_mem_model_inst.mem[98] = 32'hffffffff;
        tdf_mem_model_inst.mem[99] = 32'h00010001;
        {block_ptr, ext_block_en, stall, dyn_desc_en} <= {32'h80, 3'b000};
        go();
        chk(32'(n_bad), 32'h1);
        chk(32'(n_wr + n_done), 32'h0);
    endtask

    initial begin
        sc_simple();
        sc_ext();
        sc_bad();
        test_done();
    end
endmodule // tb_transmit_descriptor_fetch
`default_nettype wire
